//--- rtl/iom_consts.svh
`ifndef IOM_CONSTS_SVH
`define IOM_CONSTS_SVH

// serial frame layout
`define IOM_FRAME_BITS 16
`define IOM_BYTE_BITS 8
`define IOM_CNT_W 5
`define IOM_CMD_MSB 15
`define IOM_CMD_LSB 14
`define IOM_ADDR_MSB 13
`define IOM_ADDR_LSB 9
`define IOM_FB_ADDR_MSB 5
`define IOM_FB_ADDR_LSB 1
`define IOM_CMD_WRITE 2'h1

// register addresses and reset values
`define IOM_ADDR_PIN_MODE 5'h11
`define IOM_ADDR_IRQ_EN 5'h12
`define IOM_PIN_MODE_RST 8'h00
`define IOM_IRQ_EN_RST 8'h00

// pin field codes
`define IOM_MODE_OFF 2'h0
`define IOM_MODE_WAKE 2'h1
`define IOM_MODE_DRV_A 2'h2
`define IOM_MODE_DRV_B 2'h3

// interrupt enable bit positions
`define IOM_EN_CAN 7
`define IOM_EN_MCU 6
`define IOM_EN_LIN2 5
`define IOM_EN_LIN1 4
`define IOM_EN_IO 3
`define IOM_EN_SAFE 2
`define IOM_EN_VMON 0

// fault source vector positions
`define IOM_SRC_CAN 5
`define IOM_SRC_LIN2 4
`define IOM_SRC_LIN1 3
`define IOM_SRC_IO 2
`define IOM_SRC_SAFE 1
`define IOM_SRC_VMON 0
`define IOM_NUM_SRC 6

`endif

//--- rtl/iom_pkg.sv
package iom_pkg;
  // phase of the serial frame receiver
  typedef enum logic [1:0] {IOM_PH_IDLE, IOM_PH_SHIFT, IOM_PH_DROP} iom_phase_type;
  // one decoded pin: wake enable, low-side driver, high-side driver
  typedef struct packed {
    logic wake;
    logic low_side;
    logic high_side;
  } iom_pin_drive_type;
endpackage

//--- rtl/iom_spi_frame_rx.sv
`include "iom_consts.svh"

// frame receiver: samples mosi on sclk rise, shifts miso on sclk fall
module iom_spi_frame_rx
  import iom_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [15:0] frame_word,
  output logic frame_valid,
  output logic [7:0] first_byte
);
  iom_phase_type phase_r;
  logic sclk_prev_r;
  logic [`IOM_CNT_W-1:0] cnt_r;
  logic [15:0] shift_r;
  logic [7:0] tx_sh_r;
  logic load_pend_r;
  logic miso_r;
  logic valid_r;
  logic rise;
  logic fall;

  assign rise = sclk & ~sclk_prev_r;
  assign fall = ~sclk & sclk_prev_r;
  assign frame_word = shift_r;
  assign first_byte = shift_r[7:0];
  assign frame_valid = valid_r;
  assign miso = miso_r;

  always_ff @(posedge core_clk) begin
    if (rst) sclk_prev_r <= 1'b0;
    else sclk_prev_r <= sclk;
  end

  // frame phase; a frame of any length other than 16 bits is dropped
  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase_r <= IOM_PH_IDLE;
      cnt_r <= '0;
      shift_r <= '0;
      valid_r <= 1'b0;
    end else begin
      valid_r <= 1'b0;
      case (phase_r)
        IOM_PH_IDLE: begin
          cnt_r <= '0;
          if (!cs_n) phase_r <= IOM_PH_SHIFT;
        end
        IOM_PH_SHIFT: begin
          if (cs_n) begin
            phase_r <= IOM_PH_IDLE;
            valid_r <= (cnt_r == `IOM_CNT_W'(`IOM_FRAME_BITS));
          end else if (rise) begin
            if (cnt_r == `IOM_CNT_W'(`IOM_FRAME_BITS)) phase_r <= IOM_PH_DROP;
            else begin
              shift_r <= {shift_r[14:0], mosi};
              cnt_r <= cnt_r + `IOM_CNT_W'(1);
            end
          end
        end
        IOM_PH_DROP: begin
          if (cs_n) phase_r <= IOM_PH_IDLE;
        end
        default: phase_r <= IOM_PH_IDLE;
      endcase
    end
  end

  // answer byte is loaded one cycle after the first byte lands
  always_ff @(posedge core_clk) begin
    if (rst) begin
      load_pend_r <= 1'b0;
      tx_sh_r <= '0;
      miso_r <= 1'b0;
    end else if (cs_n) begin
      load_pend_r <= 1'b0;
      miso_r <= 1'b0;
    end else begin
      load_pend_r <= rise && phase_r == IOM_PH_SHIFT
                     && cnt_r == `IOM_CNT_W'(`IOM_BYTE_BITS - 1);
      if (load_pend_r) tx_sh_r <= tx_byte;
      else if (fall && cnt_r >= `IOM_CNT_W'(`IOM_BYTE_BITS)
               && cnt_r < `IOM_CNT_W'(`IOM_FRAME_BITS)) begin
        miso_r <= tx_sh_r[7];
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      end
    end
  end
endmodule // iom_spi_frame_rx

//--- rtl/iom_io_mode_irq_regs.sv
`include "iom_consts.svh"

// Summary of operation
// - A register write is a 16-bit frame whose first byte holds command, address and qualifier and whose second byte is the data.
// - The pin mode register holds four 2-bit fields, pin 3 in bits 7:6 down to pin 0 in bits 1:0.
// - Field value 00 keeps the pin driver off and ignores the pin as a wake source.
// - Field value 01 keeps the driver off and makes pin transitions a wake source.
// - On pins 0 and 1, value 10 enables the low-side driver and 11 the high-side driver.
// - On pins 2 and 3, values 10 and 11 both enable the high-side driver.
// - Enable bit 7 lets CAN failures assert the interrupt output.
// - Enable bit 6 requests one interrupt when it becomes enabled, not repeated while it stays set.
// - The requested interrupt needs bits 6 and 2 both set; bit 6 alone does nothing.
// - Enable bit 5 lets second LIN faults assert the interrupt output, and clearing it suppresses them.
// - Enable bit 4 lets first LIN faults assert the interrupt output, and clearing it suppresses them.
// - Enable bit 3 lets I/O pin failures assert the interrupt output, and clearing it suppresses them.
// - Enable bit 2 lets safety events assert the interrupt output.
// - Enable bit 0 lets regulator monitoring events assert the interrupt output.
module iom_io_mode_irq_regs
  import iom_pkg::*;
#(
  parameter int INT_PULSE_CYCLES = 10
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  input wire logic [3:0] io_pin,
  input wire logic can_fault,
  input wire logic second_lin_fault,
  input wire logic first_lin_fault,
  input wire logic io_fault,
  input wire logic safe_fault,
  input wire logic vmon_fault,
  input wire logic [5:0] fault_clear,
  output logic [5:0] fault_seen_r,
  output logic [3:0] low_side_driver_r,
  output logic [3:0] high_side_driver_r,
  output logic [3:0] wake_enable_r,
  output logic [3:0] wake_event_r,
  output logic [7:0] pin_mode_config_r,
  output logic [7:0] irq_source_enable_r,
  output logic int_n_r
);
  localparam int CNT_W = $clog2(INT_PULSE_CYCLES + 1);

  generate
    if (INT_PULSE_CYCLES < 1) begin : g_bad_pulse
      $error("INT_PULSE_CYCLES must be at least one");
    end
  endgenerate

  logic [15:0] frame_word;
  logic frame_valid;
  logic [7:0] first_byte;
  logic [7:0] tx_byte;
  logic [3:0] pin_prev_r;
  logic [5:0] fault_in;
  logic mcu_arm;
  logic mcu_arm_prev_r;
  logic mcu_start;
  logic [CNT_W-1:0] mcu_cnt_r;
  logic wr_pin;
  logic wr_irq;
  logic miso_int;
  logic [3:0] dec_low;
  logic [3:0] dec_high;
  logic [3:0] dec_wake;

  // field decode shared by all four pins
  function automatic iom_pin_drive_type pin_drive(input logic [1:0] code, input logic low_ok);
    iom_pin_drive_type d;
    d = '0;
    case (code)
      `IOM_MODE_OFF: d = '0;
      `IOM_MODE_WAKE: d.wake = 1'b1;
      `IOM_MODE_DRV_A: begin
        d.low_side = low_ok;
        d.high_side = !low_ok;
      end
      `IOM_MODE_DRV_B: d.high_side = 1'b1;
      default: d = '0;
    endcase
    return d;
  endfunction

  // enable bits reordered into the fault source vector
  function automatic logic [5:0] src_enables(input logic [7:0] en);
    return {en[`IOM_EN_CAN], en[`IOM_EN_LIN2], en[`IOM_EN_LIN1],
            en[`IOM_EN_IO], en[`IOM_EN_SAFE], en[`IOM_EN_VMON]};
  endfunction

  // register read-back follows the address in the first byte
  function automatic logic [7:0] read_mux(input logic [4:0] addr, input logic [7:0] pm,
                                          input logic [7:0] en);
    if (addr == `IOM_ADDR_PIN_MODE) return pm;
    else if (addr == `IOM_ADDR_IRQ_EN) return en;
    else return 8'h00;
  endfunction

  iom_spi_frame_rx u_rx (
    .core_clk(core_clk),
    .rst(rst),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .tx_byte(tx_byte),
    .miso(miso_int),
    .frame_word(frame_word),
    .frame_valid(frame_valid),
    .first_byte(first_byte)
  );

  assign miso = miso_int;
  assign tx_byte = read_mux(first_byte[`IOM_FB_ADDR_MSB:`IOM_FB_ADDR_LSB],
                            pin_mode_config_r, irq_source_enable_r);

  // write decode; the qualifier bit in the first byte is not checked
  assign wr_pin = frame_valid && frame_word[`IOM_CMD_MSB:`IOM_CMD_LSB] == `IOM_CMD_WRITE
                  && frame_word[`IOM_ADDR_MSB:`IOM_ADDR_LSB] == `IOM_ADDR_PIN_MODE;
  assign wr_irq = frame_valid && frame_word[`IOM_CMD_MSB:`IOM_CMD_LSB] == `IOM_CMD_WRITE
                  && frame_word[`IOM_ADDR_MSB:`IOM_ADDR_LSB] == `IOM_ADDR_IRQ_EN;

  // control registers load the second byte
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_mode_config_r <= `IOM_PIN_MODE_RST;
      irq_source_enable_r <= `IOM_IRQ_EN_RST;
    end else begin
      if (wr_pin) pin_mode_config_r <= frame_word[7:0];
      if (wr_irq) irq_source_enable_r <= frame_word[7:0];
    end
  end

  // per-pin decode kept combinational so the flops below take plain vectors
  always_comb begin
    iom_pin_drive_type d;
    d = '0;
    dec_low = '0;
    dec_high = '0;
    dec_wake = '0;
    for (int i = 0; i < 4; i++) begin
      d = pin_drive(pin_mode_config_r[2*i +: 2], i < 2);
      dec_low[i] = d.low_side;
      dec_high[i] = d.high_side;
      dec_wake[i] = d.wake;
    end
  end

  // pin outputs; low-side only on pins 0 and 1
  always_ff @(posedge core_clk) begin
    if (rst) begin
      low_side_driver_r <= '0;
      high_side_driver_r <= '0;
      wake_enable_r <= '0;
    end else begin
      low_side_driver_r <= dec_low;
      high_side_driver_r <= dec_high;
      wake_enable_r <= dec_wake;
    end
  end

  // wake pulse on any edge of an enabled pin
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_prev_r <= '0;
      wake_event_r <= '0;
    end else begin
      pin_prev_r <= io_pin;
      wake_event_r <= wake_enable_r & (io_pin ^ pin_prev_r);
    end
  end

  assign fault_in = {can_fault, second_lin_fault, first_lin_fault,
                     io_fault, safe_fault, vmon_fault};

  // faults recorded whatever the enables say; a new fault beats a clear
  always_ff @(posedge core_clk) begin
    if (rst) fault_seen_r <= '0;
    else fault_seen_r <= (fault_seen_r & ~fault_clear) | fault_in;
  end

  // host request arms only with the safety bit also set
  assign mcu_arm = irq_source_enable_r[`IOM_EN_MCU]
                   & irq_source_enable_r[`IOM_EN_SAFE];
  assign mcu_start = mcu_arm & ~mcu_arm_prev_r;

  // one fixed-width pulse per arming edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mcu_arm_prev_r <= 1'b0;
      mcu_cnt_r <= '0;
    end else begin
      mcu_arm_prev_r <= mcu_arm;
      if (mcu_start) mcu_cnt_r <= CNT_W'(INT_PULSE_CYCLES - 1);
      else if (mcu_cnt_r != '0) mcu_cnt_r <= mcu_cnt_r - CNT_W'(1);
    end
  end

  // interrupt output, active low; a fault keeps it low while recorded and enabled
  always_ff @(posedge core_clk) begin
    if (rst) int_n_r <= 1'b1;
    else int_n_r <= !(|(fault_seen_r & src_enables(irq_source_enable_r))
                      || mcu_start || mcu_cnt_r != '0);
  end

  a_pin_write_loads: assert property (@(posedge core_clk) disable iff (rst)
    wr_pin |=> pin_mode_config_r == $past(frame_word[7:0]))
    else $error("pin mode write did not load data byte");

  a_off_field_idle: assert property (@(posedge core_clk) disable iff (rst)
    pin_mode_config_r[1:0] == `IOM_MODE_OFF
    |=> (!low_side_driver_r[0] && !high_side_driver_r[0] && !wake_enable_r[0])
    ##1 wake_event_r[0] == 1'b0)
    else $error("pin 0 off mode still active");

  a_wake_edge_pulse: assert property (@(posedge core_clk) disable iff (rst)
    wake_enable_r[2] && (io_pin[2] != pin_prev_r[2]) |=> wake_event_r[2])
    else $error("wake transition not reported");

  a_low_side_pin1: assert property (@(posedge core_clk) disable iff (rst)
    pin_mode_config_r[3:2] == `IOM_MODE_DRV_A |=> low_side_driver_r[1] && !high_side_driver_r[1])
    else $error("pin 1 low-side mode wrong");

  a_high_side_pin3: assert property (@(posedge core_clk) disable iff (rst)
    pin_mode_config_r[7] |=> high_side_driver_r[3] && !low_side_driver_r[3])
    else $error("pin 3 high-side mode wrong");

  a_mcu_single_pulse: assert property (@(posedge core_clk) disable iff (rst)
    mcu_arm && mcu_arm_prev_r && mcu_cnt_r == '0 |=> mcu_cnt_r == '0 && !mcu_start)
    else $error("host request interrupt repeated");

  a_mcu_needs_safe: assert property (@(posedge core_clk) disable iff (rst)
    !irq_source_enable_r[`IOM_EN_SAFE] && mcu_cnt_r == '0 |=> mcu_cnt_r == '0)
    else $error("host request fired without safety bit");

  a_lin2_irq_out: assert property (@(posedge core_clk) disable iff (rst)
    fault_seen_r[`IOM_SRC_LIN2] && irq_source_enable_r[`IOM_EN_LIN2] |=> !int_n_r)
    else $error("second lin fault not signalled");

  a_fault_recorded: assert property (@(posedge core_clk) disable iff (rst)
    first_lin_fault |=> fault_seen_r[`IOM_SRC_LIN1])
    else $error("first lin fault not recorded");

  a_masked_quiet: assert property (@(posedge core_clk) disable iff (rst)
    (fault_seen_r & src_enables(irq_source_enable_r)) == '0 && mcu_cnt_r == '0
    && !mcu_start |=> int_n_r)
    else $error("interrupt without enabled cause");
endmodule // iom_io_mode_irq_regs

//--- tb/iom_host_model.sv
// host side serial master: sclk idles low and only moves inside a frame
module iom_host_model (
  input wire logic core_clk,
  input wire logic miso,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle levels from time zero, no frame open
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // inputs change a fixed 10 ns after the core edge
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #10;
  endtask

  // one whole frame of 16 bits, msb first; miso taken at rises 9..16
  // low phase is 3 core cycles so the answer bit has landed before the rise
  task automatic xfer(input logic [15:0] word, output logic [7:0] rd);
    rd = 8'h00;
    step(1);
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi = word[i];
      step(3);
      if (i < 8) rd = {rd[6:0], miso};
      sclk = 1'b1;
      step(2);
      sclk = 1'b0;
    end
    step(2);
    cs_n = 1'b1;
    mosi = ~mosi; // a released line does not keep its last value
    step(3);
  endtask
endmodule // iom_host_model

//--- tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PULSE = 3;
  logic core_clk, rst, sclk, cs_n, mosi, miso, int_n_r;
  logic [3:0] io_pin, low_side_driver_r, high_side_driver_r, wake_enable_r, wake_event_r;
  logic [5:0] flt, fault_clear, fault_seen_r;
  logic [7:0] pin_mode_config_r, irq_source_enable_r, rd;
  int miscompares, cmp_count, low_cnt, wk0_cnt, wk1_cnt;

  iom_host_model u_iom_host_model (.core_clk(core_clk), .miso(miso), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi));

  iom_io_mode_irq_regs #(.INT_PULSE_CYCLES(PULSE)) u_iom_io_mode_irq_regs (
    .core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .io_pin(io_pin), .can_fault(flt[5]), .second_lin_fault(flt[4]),
    .first_lin_fault(flt[3]), .io_fault(flt[2]), .safe_fault(flt[1]),
    .vmon_fault(flt[0]), .fault_clear(fault_clear), .fault_seen_r(fault_seen_r),
    .low_side_driver_r(low_side_driver_r), .high_side_driver_r(high_side_driver_r),
    .wake_enable_r(wake_enable_r), .wake_event_r(wake_event_r),
    .pin_mode_config_r(pin_mode_config_r), .irq_source_enable_r(irq_source_enable_r),
    .int_n_r(int_n_r));

  // 10 MHz core clock
  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  // background counts of interrupt-low cycles and wake pulses, read mid-cycle when settled
  always @(negedge core_clk) begin
    if (int_n_r === 1'b0) low_cnt++;
    if (wake_event_r[0] === 1'b1) wk0_cnt++;
    if (wake_event_r[1] === 1'b1) wk1_cnt++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #10;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // frame: command, address, ignored qualifier, data; rd gets the old value
  task automatic wr(input logic [1:0] cmd, input logic [4:0] adr, input logic [7:0] d);
    u_iom_host_model.xfer({cmd, adr, 1'b0, d}, rd);
    cyc(2);
  endtask

  // one-cycle pulse on a fault input, or on its clear when clr is set
  task automatic hit(input int s, input logic clr);
    if (clr) fault_clear[s] = 1'b1;
    else flt[s] = 1'b1;
    cyc(1);
    fault_clear = 6'h00;
    flt = 6'h00;
    cyc(3);
  endtask

  task automatic t_reset();
    chk(pin_mode_config_r, 8'h00);
    chk(irq_source_enable_r, 8'h00);
    chk({7'h00, int_n_r}, 8'h01);
  endtask

  // all four codes on every pin, then a mixed value for field placement
  task automatic t_pins();
    logic [7:0] prev;
    logic [7:0] tab [5];
    logic [1:0] c;
    logic [3:0] lo, hi, wk;
    tab = '{8'h00, 8'h55, 8'hAA, 8'hFF, 8'h1B};
    prev = 8'h00;
    foreach (tab[k]) begin
      wr(2'h1, 5'h11, tab[k]);
      chk(rd, prev);
      chk(pin_mode_config_r, tab[k]);
      for (int p = 0; p < 4; p++) begin
        c = tab[k][2*p +: 2];
        lo[p] = (c == 2'h2) && (p < 2);
        hi[p] = (c == 2'h3) || ((c == 2'h2) && (p >= 2));
        wk[p] = (c == 2'h1);
      end
      chk({4'h0, low_side_driver_r}, {4'h0, lo});
      chk({4'h0, high_side_driver_r}, {4'h0, hi});
      chk({4'h0, wake_enable_r}, {4'h0, wk});
      prev = tab[k];
    end
  endtask

  // unknown address and read command leave both registers alone
  task automatic t_unmapped();
    wr(2'h1, 5'h13, 8'hFF);
    chk(rd, 8'h00);
    chk(pin_mode_config_r, 8'h1B);
    chk(irq_source_enable_r, 8'h00);
    wr(2'h0, 5'h11, 8'h00);
    chk(rd, 8'h1B);
    chk(pin_mode_config_r, 8'h1B);
  endtask

  // each source enabled alone raises the interrupt; disabled it is only recorded
  task automatic t_faults();
    int bitpos [6];
    bitpos = '{0, 2, 3, 4, 5, 7};
    for (int s = 0; s < 6; s++) begin
      wr(2'h1, 5'h12, 8'h01 << bitpos[s]);
      hit(s, 1'b0);
      chk({7'h00, int_n_r}, 8'h00);
      chk({2'h0, fault_seen_r}, 8'h01 << s);
      hit(s, 1'b1);
      chk({7'h00, int_n_r}, 8'h01);
      wr(2'h1, 5'h12, 8'h00);
      hit(s, 1'b0);
      chk({7'h00, int_n_r}, 8'h01);
      chk({2'h0, fault_seen_r}, 8'h01 << s);
      hit(s, 1'b1);
    end
  endtask

  // host request: bit 6 alone nothing, with bit 2 exactly one pulse
  task automatic t_host();
    low_cnt = 0;
    wr(2'h1, 5'h12, 8'h40);
    cyc(PULSE + 4);
    chk(low_cnt[7:0], 8'h00);
    wr(2'h1, 5'h12, 8'h44);
    cyc(PULSE + 4);
    chk(low_cnt[7:0], 8'(PULSE));
    cyc(20);
    chk(low_cnt[7:0], 8'(PULSE));
    wr(2'h1, 5'h12, 8'h04);
    wr(2'h1, 5'h12, 8'h44);
    cyc(PULSE + 4);
    chk(low_cnt[7:0], 8'(2 * PULSE));
    wr(2'h1, 5'h12, 8'h00);
  endtask

  // pins 0, 2 and 3 wake-capable, pin 1 off: pin 1 edges never count
  task automatic t_wake();
    wr(2'h1, 5'h11, 8'h51);
    wk0_cnt = 0;
    wk1_cnt = 0;
    io_pin = 4'hF;
    cyc(1);
    chk({4'h0, wake_event_r}, 8'h0D);
    cyc(2);
    io_pin = 4'h0;
    cyc(3);
    chk(wk0_cnt[7:0], 8'h02);
    chk(wk1_cnt[7:0], 8'h00);
  endtask

  // main sequence: reset held 16 cycles, then each scenario in turn
  initial begin
    rst = 1'b1;
    io_pin = 4'h0;
    flt = 6'h00;
    fault_clear = 6'h00;
    miscompares = 0;
    cmp_count = 0;
    low_cnt = 0;
    wk0_cnt = 0;
    wk1_cnt = 0;
    cyc(16);
    rst = 1'b0;
    cyc(1);
    t_reset();
    t_pins();
    t_unmapped();
    t_faults();
    t_host();
    t_wake();
    wrap_up();
  end
endmodule // tb_top
